// ==== core/fcs_unit.sv ====
/*
  Floating-point compare and status register instruction unit.
  Holds the status register and the condition register, executes compares
  and status instructions issued one at a time, and exposes both registers
  over a Wishbone classic slave.  Assumes the issue logic presents one
  instruction at a time and honours the hold output for later floating-point
  arithmetic; earlier-instruction and exception pending levels come from
  logic on the same clock.
*/
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module fcs_unit
  import fcs_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Instruction issue port.
  input wire logic i_op_valid,
  output logic o_op_ready,
  input wire logic [2:0] i_op_code,
  input wire logic i_op_dot,
  input wire logic [0:63] i_first_fp_operand,
  input wire logic [0:63] i_second_fp_operand,
  input wire logic [2:0] i_target_cr_field,
  input wire logic [2:0] i_source_status_field,
  input wire logic [4:0] i_target_status_bit,
  input wire logic [3:0] i_four_bit_constant,
  input wire logic [7:0] i_field_mask_operand,
  // Completion and results.
  output logic o_op_done,
  output logic [0:63] o_fp_destination,
  output logic [0:31] o_condition_reg,
  output logic [0:31] o_fp_status_control_reg,
  // Pipeline synchronisation.
  input wire logic i_earlier_fp_pending,
  input wire logic i_exc_record_pending,
  input wire logic i_handler_pending,
  output logic o_hold_later_fp,
  output logic o_hold_fp_mem,
  // Exception recording from other floating-point units.
  input wire logic i_exc_set_valid,
  input wire logic [0:31] i_exc_set_bits,
  // Wishbone classic slave.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack
);

  typedef struct packed {
    fcs_state_type state;
    fcs_op_type op;
    logic dot;
    logic [0:63] opa;
    logic [0:63] opb;
    logic [2:0] crf;
    logic [2:0] srcf;
    logic [4:0] bitpos;
    logic [3:0] four_bit_constant;
    logic [7:0] mask;
    logic [0:31] status;
    logic [0:31] cond;
    logic [0:63] dest;
    logic [3:0] last_cmp;
    logic done;
    logic ack;
    logic [31:0] rdata;
  } fcs_regs_type;

  fcs_regs_type r_reg;
  fcs_regs_type r_next;

  // A NaN has an all-ones exponent and a non-zero fraction.
  function automatic logic is_nan(input logic [0:63] v);
    is_nan = (v[1:11] == 11'h7FF) && (v[12:63] != 52'h0000000000000);
  endfunction

  // Signalling NaNs have the leading fraction bit clear.
  function automatic logic is_snan(input logic [0:63] v);
    is_snan = is_nan(v) && !v[12];
  endfunction

  // Four-bit compare outcome with exactly one bit set.
  function automatic logic [3:0] cmp_outcome(input logic [0:63] a, input logic [0:63] b);
    logic za;
    logic zb;
    logic lt;
    logic [3:0] res;
    za = (a[1:63] == 63'h0);
    zb = (b[1:63] == 63'h0);
    res = 4'h0;
    lt = 1'b0;
    if (a[0] != b[0]) begin
      lt = a[0];
    end else if (a[0]) begin
      lt = a[1:63] > b[1:63];
    end else begin
      lt = a[1:63] < b[1:63];
    end
    // Field bit 0 is the leftmost, so index 3 minus position in a [3:0] vector.
    if (is_nan(a) || is_nan(b)) begin
      res[3 - FCS_CMP_UN] = 1'b1;
    end else if ((za && zb) || (a == b)) begin
      res[3 - FCS_CMP_EQ] = 1'b1;
    end else if (lt) begin
      res[3 - FCS_CMP_LT] = 1'b1;
    end else begin
      res[3 - FCS_CMP_GT] = 1'b1;
    end
    cmp_outcome = res;
  endfunction

  // Summary bits are always derived, so a write of them never sticks.
  function automatic logic [0:31] summarise(input logic [0:31] s);
    logic [0:31] t;
    logic inv;
    t = s;
    inv = |(s & FCS_INV_SRC_MASK);
    t[FCS_BIT_INV_SUM] = inv;
    t[FCS_BIT_ENA_SUM] = (inv & s[FCS_BIT_INV_ENA]) | (s[FCS_BIT_OVF] & s[FCS_BIT_OVF_ENA])
      | (s[FCS_BIT_UNF] & s[FCS_BIT_UNF_ENA]) | (s[FCS_BIT_ZDIV] & s[FCS_BIT_ZDIV_ENA])
      | (s[FCS_BIT_INEX] & s[FCS_BIT_INEX_ENA]);
    summarise = t;
  endfunction

  // Merge a bus word into a register under the byte lane enables.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int k = 0; k < 4; k++) begin
      if (sel[k]) begin
        m[8*k +: 8] = nw[8*k +: 8];
      end
    end
    merge = m;
  endfunction

  logic is_status_op;
  logic sync_clear;
  logic [3:0] cmp_res;
  logic [4:0] cc_base;
  logic [4:0] crf_base;
  logic [4:0] srcf_base;

  // Decode helpers from the latched instruction, and the sync condition from the pending levels.
  assign is_status_op = (r_reg.op != FCS_OP_CMP_UNORD) && (r_reg.op != FCS_OP_CMP_ORD);
  assign sync_clear = !i_earlier_fp_pending && !i_exc_record_pending && !i_handler_pending;
  assign cmp_res = cmp_outcome(r_reg.opa, r_reg.opb);
  assign crf_base = {r_reg.crf, 2'b00};
  assign srcf_base = {r_reg.srcf, 2'b00};
  assign cc_base = FCS_CC_FIELD << 2;

  // Next-state logic: bus access, then instruction, then recorded exceptions.
  always_comb begin
    logic [0:31] st;
    logic [0:31] cr;
    logic [0:31] wsrc;
    logic [3:0] fld;
    st = r_reg.status;
    cr = r_reg.cond;
    wsrc = 32'h00000000;
    fld = 4'h0;
    r_next = r_reg;
    r_next.done = 1'b0;

    // Classic single cycle: the write lands at the edge where ack is seen.
    r_next.ack = i_wb_cyc && i_wb_stb && !r_reg.ack;
    if (i_wb_cyc && i_wb_stb && !r_reg.ack) begin
      unique case (i_wb_adr)
        FCS_ADDR_STATUS: r_next.rdata = r_reg.status;
        FCS_ADDR_COND: r_next.rdata = r_reg.cond;
        FCS_ADDR_INFO: r_next.rdata = {24'h000000, r_reg.last_cmp, 2'b00, r_reg.state};
        FCS_ADDR_DEST_HI: r_next.rdata = r_reg.dest[32:63];
        default: r_next.rdata = 32'h00000000;
      endcase
    end
    if (i_wb_cyc && i_wb_stb && r_reg.ack && i_wb_we) begin
      if (i_wb_adr == FCS_ADDR_STATUS) begin
        st = merge(st, i_wb_dat, i_wb_sel);
      end else if (i_wb_adr == FCS_ADDR_COND) begin
        cr = merge(cr, i_wb_dat, i_wb_sel);
      end
    end

    // Instruction sequencer.
    unique case (r_reg.state)
      FCS_ST_IDLE: begin
        if (i_op_valid) begin
          r_next.op = fcs_op_type'(i_op_code);
          r_next.dot = i_op_dot;
          r_next.opa = i_first_fp_operand;
          r_next.opb = i_second_fp_operand;
          r_next.crf = i_target_cr_field;
          r_next.srcf = i_source_status_field;
          r_next.bitpos = i_target_status_bit;
          r_next.four_bit_constant = i_four_bit_constant;
          r_next.mask = i_field_mask_operand;
          // Compares go straight to execution; status ops synchronise first.
          if ((i_op_code == FCS_OP_CMP_UNORD) || (i_op_code == FCS_OP_CMP_ORD)) begin
            r_next.state = FCS_ST_EXEC;
          end else begin
            r_next.state = FCS_ST_SYNC;
          end
        end
      end
      FCS_ST_SYNC: begin
        // Start only once earlier work, exception recording and handlers are over.
        if (sync_clear) begin
          r_next.state = FCS_ST_EXEC;
        end
      end
      FCS_ST_EXEC: begin
        r_next.state = FCS_ST_DONE;
        unique case (r_reg.op)
          FCS_OP_CMP_UNORD, FCS_OP_CMP_ORD: begin
            cr[crf_base +: 4] = cmp_res;
            st[cc_base +: 4] = cmp_res;
            r_next.last_cmp = cmp_res;
            // Ordered compares flag any NaN; unordered only signalling ones.
            if ((r_reg.op == FCS_OP_CMP_ORD) && cmp_res[3 - FCS_CMP_UN]) begin
              st[FCS_BIT_INV_CMP] = 1'b1;
              st[FCS_BIT_STICKY] = 1'b1;
            end
            if (is_snan(r_reg.opa) || is_snan(r_reg.opb)) begin
              st[FCS_BIT_INV_SNAN] = 1'b1;
              st[FCS_BIT_STICKY] = 1'b1;
            end
          end
          FCS_OP_READ_STATUS: begin
            // The undefined upper half is driven as zero.
            r_next.dest = {32'h00000000, st};
          end
          FCS_OP_COPY_FIELD: begin
            fld = st[srcf_base +: 4];
            cr[crf_base +: 4] = fld;
            st[srcf_base +: 4] = fld & ~(FCS_EXC_MASK[srcf_base +: 4]
              & ~FCS_SUMMARY_MASK[srcf_base +: 4]);
          end
          FCS_OP_WRITE_IMM: begin
            // Field 0 alone holds the sticky bit, so other fields leave it.
            st[crf_base +: 4] = r_reg.four_bit_constant;
          end
          FCS_OP_WRITE_MASKED: begin
            wsrc = r_reg.opb[32:63];
            for (int i = 0; i < 8; i++) begin
              if (r_reg.mask[7 - i]) begin
                st[4*i +: 4] = wsrc[4*i +: 4];
              end
            end
          end
          FCS_OP_CLEAR_BIT: begin
            if (!FCS_SUMMARY_MASK[r_reg.bitpos]) begin
              st[r_reg.bitpos] = 1'b0;
            end
          end
          FCS_OP_SET_BIT: begin
            if (!FCS_SUMMARY_MASK[r_reg.bitpos]) begin
              st[r_reg.bitpos] = 1'b1;
            end
          end
        endcase
      end
      FCS_ST_DONE: begin
        r_next.state = FCS_ST_IDLE;
        r_next.done = 1'b1;
      end
    endcase

    // Recorded exceptions are set last so a set wins over any clear.
    if (i_exc_set_valid) begin
      st = st | i_exc_set_bits;
    end
    st = summarise(st);

    // Dot forms other than compares and the field copy copy the first status field into the fixed CR field.
    if ((r_reg.state == FCS_ST_EXEC) && r_reg.dot && is_status_op
        && (r_reg.op != FCS_OP_COPY_FIELD)) begin
      cr[{FCS_DOT_CR_FIELD, 2'b00} +: 4] = st[0:3];
    end
    r_next.status = st;
    r_next.cond = cr;
  end

  // State register.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      r_reg.state <= FCS_ST_IDLE;
      r_reg.op <= FCS_OP_CMP_UNORD;
      r_reg.dot <= 1'b0;
      r_reg.opa <= FCS_DEST_RESET;
      r_reg.opb <= FCS_DEST_RESET;
      r_reg.crf <= 3'h0;
      r_reg.srcf <= 3'h0;
      r_reg.bitpos <= 5'h00;
      r_reg.four_bit_constant <= 4'h0;
      r_reg.mask <= 8'h00;
      r_reg.status <= FCS_STATUS_RESET;
      r_reg.cond <= FCS_COND_RESET;
      r_reg.dest <= FCS_DEST_RESET;
      r_reg.last_cmp <= 4'h0;
      r_reg.done <= 1'b0;
      r_reg.ack <= 1'b0;
      r_reg.rdata <= 32'h00000000;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs.  The hold covers the whole status op, sync wait included.
  assign o_op_ready = (r_reg.state == FCS_ST_IDLE);
  assign o_hold_later_fp = (r_reg.state != FCS_ST_IDLE) && is_status_op;
  assign o_hold_fp_mem = 1'b0;
  assign o_op_done = r_reg.done;
  assign o_fp_destination = r_reg.dest;
  assign o_condition_reg = r_reg.cond;
  assign o_fp_status_control_reg = r_reg.status;
  assign o_wb_dat = r_reg.rdata;
  assign o_wb_ack = r_reg.ack;

endmodule // fcs_unit

// ==== core/fcs_pkg.sv ====
/*
  Shared constants and types for the floating-point compare and status unit.
  Assumes a core clock, a synchronous active-high reset and a Wishbone classic
  register bus with 32-bit data.  Status and condition vectors are numbered
  with bit 0 as the most significant bit.
*/
package fcs_pkg;
  // Register bus byte offsets.
  localparam logic [7:0] FCS_ADDR_STATUS = 8'h00;
  localparam logic [7:0] FCS_ADDR_COND = 8'h04;
  localparam logic [7:0] FCS_ADDR_INFO = 8'h08;
  localparam logic [7:0] FCS_ADDR_DEST_HI = 8'h0C;

  // Values after reset.
  localparam logic [0:31] FCS_STATUS_RESET = 32'h00000000;
  localparam logic [0:31] FCS_COND_RESET = 32'h00000000;
  localparam logic [0:63] FCS_DEST_RESET = 64'h0000000000000000;

  // Exception, summary, enable and condition code positions in the status register, and the dot-form CR field.
  localparam int FCS_BIT_STICKY = 0;
  localparam int FCS_BIT_ENA_SUM = 1;
  localparam int FCS_BIT_INV_SUM = 2;
  localparam int FCS_BIT_OVF = 3;
  localparam int FCS_BIT_UNF = 4;
  localparam int FCS_BIT_ZDIV = 5;
  localparam int FCS_BIT_INEX = 6;
  localparam int FCS_BIT_INV_SNAN = 7;
  localparam int FCS_BIT_INV_CMP = 12;
  localparam int FCS_BIT_INV_ENA = 24;
  localparam int FCS_BIT_OVF_ENA = 25;
  localparam int FCS_BIT_UNF_ENA = 26;
  localparam int FCS_BIT_ZDIV_ENA = 27;
  localparam int FCS_BIT_INEX_ENA = 28;
  localparam logic [4:0] FCS_CC_FIELD = 5'h04;
  localparam logic [2:0] FCS_DOT_CR_FIELD = 3'h1;

  // Individual invalid-operation bits that the invalid summary gathers.
  localparam logic [0:31] FCS_INV_SRC_MASK = 32'h01F80700;
  // Exception bits that a field copy to the condition register clears.
  localparam logic [0:31] FCS_EXC_MASK = 32'h9FF80700;
  // The two summary bits that only the hardware derives.
  localparam logic [0:31] FCS_SUMMARY_MASK = 32'h60000000;

  // Compare outcome positions within a four-bit field.
  localparam int FCS_CMP_LT = 0;
  localparam int FCS_CMP_GT = 1;
  localparam int FCS_CMP_EQ = 2;
  localparam int FCS_CMP_UN = 3;

  // Instruction codes on the issue port.
  typedef enum logic [2:0] {
    FCS_OP_CMP_UNORD = 3'h0,
    FCS_OP_CMP_ORD = 3'h1,
    FCS_OP_READ_STATUS = 3'h2,
    FCS_OP_COPY_FIELD = 3'h3,
    FCS_OP_WRITE_IMM = 3'h4,
    FCS_OP_WRITE_MASKED = 3'h5,
    FCS_OP_CLEAR_BIT = 3'h6,
    FCS_OP_SET_BIT = 3'h7
  } fcs_op_type;

  // Sequencer states, Gray coded along idle, sync, exec, done.
  typedef enum logic [1:0] {
    FCS_ST_IDLE = 2'h0,
    FCS_ST_SYNC = 2'h1,
    FCS_ST_EXEC = 2'h3,
    FCS_ST_DONE = 2'h2
  } fcs_state_type;
endpackage

// ==== verification/fcs_unit_assertions.sv ====
/*
  Concurrent checks on the compare and status unit, seen from its top ports.
  Assumes one core clock with a synchronous active-high reset.
*/
`timescale 1ns/1ps
module fcs_unit_assertions
  import fcs_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Issue port.
  input wire logic i_op_valid,
  input wire logic o_op_ready,
  input wire logic [2:0] i_op_code,
  input wire logic [0:63] i_first_fp_operand,
  input wire logic [0:63] i_second_fp_operand,
  input wire logic [2:0] i_target_cr_field,
  // Results.
  input wire logic o_op_done,
  input wire logic [0:63] o_fp_destination,
  input wire logic [0:31] o_condition_reg,
  input wire logic [0:31] o_fp_status_control_reg,
  // Synchronisation.
  input wire logic i_earlier_fp_pending,
  input wire logic i_exc_record_pending,
  input wire logic i_handler_pending,
  input wire logic o_hold_later_fp,
  input wire logic o_hold_fp_mem
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  logic tk_cmp, tk_st, pend, rd_reg;
  logic [0:31] st;
  // Take strobes split by kind; status ops are codes two and up.
  assign tk_cmp = i_op_valid && o_op_ready && (i_op_code < 3'h2);
  assign tk_st = i_op_valid && o_op_ready && (i_op_code >= 3'h2);
  assign pend = i_earlier_fp_pending || i_exc_record_pending || i_handler_pending;
  assign st = o_fp_status_control_reg;
  // Remembers whether the op in flight is a status read, for its completion.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rd_reg <= 1'b0;
    end else if (i_op_valid && o_op_ready) begin
      rd_reg <= (i_op_code == FCS_OP_READ_STATUS);
    end
  end
  property p_zero;
    tk_cmp && (i_first_fp_operand[1:63] == '0) && (i_second_fp_operand[1:63] == '0)
      |-> ##3 st[16:19] == 4'h2;
  endproperty
  a_zero: assert property (p_zero) else $error("zeros not equal");
  property p_one_hot;
    tk_cmp |-> ##3 $countones(st[16:19]) == 1;
  endproperty
  a_one_hot: assert property (p_one_hot) else $error("outcome not one-hot");
  property p_cc_same;
    logic [2:0] f;
    (tk_cmp, f = i_target_cr_field) |-> ##3 o_condition_reg[4*f +: 4] == st[16:19];
  endproperty
  a_cc_same: assert property (p_cc_same) else $error("field and code differ");
  property p_cmp_time;
    tk_cmp |-> ##3 o_op_done;
  endproperty
  a_cmp_time: assert property (p_cmp_time) else $error("compare late");
  property p_hold;
    tk_st |=> o_hold_later_fp;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not raised");
  property p_sync;
    $rose(o_hold_later_fp) && pend |-> !o_op_done [*3];
  endproperty
  a_sync: assert property (p_sync) else $error("ran while pending");
  property p_hold_end;
    $fell(o_hold_later_fp) |-> o_op_done;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("hold fell early");
  property p_mem;
    o_hold_later_fp |-> !o_hold_fp_mem ##1 !o_hold_fp_mem;
  endproperty
  a_mem: assert property (p_mem) else $error("memory ops held");
  property p_read;
    o_op_done && rd_reg |-> o_fp_destination[32:63] == st;
  endproperty
  a_read: assert property (p_read) else $error("read result wrong");
  property p_sums;
    st[1] == |(st[2:6] & st[24:28]) && st[2] == |(st & FCS_INV_SRC_MASK);
  endproperty
  a_sums: assert property (p_sums) else $error("summary stale");
  // Main scenarios seen at least once.
  c_cmp: cover property (tk_cmp ##3 o_op_done);
  c_sync: cover property ($rose(o_hold_later_fp) && pend);
  c_read: cover property (o_op_done && rd_reg);
endmodule // fcs_unit_assertions

bind fcs_unit fcs_unit_assertions chk_u (.i_clk_sys, .i_reset, .i_op_valid, .o_op_ready,
  .i_op_code, .i_first_fp_operand, .i_second_fp_operand, .i_target_cr_field, .o_op_done,
  .o_fp_destination, .o_condition_reg, .o_fp_status_control_reg, .i_earlier_fp_pending,
  .i_exc_record_pending, .i_handler_pending, .o_hold_later_fp, .o_hold_fp_mem);

// ==== verification/fcs_issue_model.sv ====
/*
  Issue-side model: raises the three pending levels for a programmed time.
  Assumes the bench pulses i_start at the edge that hands over a status op.
*/
`timescale 1ns/1ps
module fcs_issue_model (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Control from the bench.
  input wire logic i_start,
  input wire logic [3:0] i_len,
  // Pending levels towards the unit.
  output logic o_earlier_fp_pending,
  output logic o_exc_record_pending,
  output logic o_handler_pending
);
  logic [3:0] cnt_reg;
  // Counts down the time that older work still needs.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cnt_reg <= 4'h0;
    end else if (i_start) begin
      cnt_reg <= i_len;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
  // Older work drains first; handlers finish last, so each level falls apart.
  assign o_earlier_fp_pending = cnt_reg > 4'h2;
  assign o_exc_record_pending = cnt_reg > 4'h1;
  assign o_handler_pending = cnt_reg != 4'h0;
endmodule // fcs_issue_model

// ==== verification/fcs_unit_tb.sv ====
/*
  Self-checking bench for the compare and status unit.
  Assumes the issue model for pending levels and drives Wishbone as master.
*/
`timescale 1ns/1ps
module fcs_unit_tb
  import fcs_pkg::*;
;
  logic i_clk_sys, i_reset, i_op_valid, i_op_dot, i_wb_cyc, i_wb_stb, i_wb_we, stt;
  logic i_exc_set_valid, o_op_ready, o_op_done, o_hold_later_fp, o_hold_fp_mem, o_wb_ack;
  logic i_earlier_fp_pending, i_exc_record_pending, i_handler_pending;
  logic [2:0] i_op_code, i_target_cr_field, i_source_status_field;
  logic [4:0] i_target_status_bit;
  logic [3:0] i_four_bit_constant, i_wb_sel, ln;
  logic [7:0] i_field_mask_operand, i_wb_adr;
  logic [63:0] i_first_fp_operand, i_second_fp_operand;
  logic [31:0] i_exc_set_bits, i_wb_dat, o_wb_dat, rq;
  logic [0:63] o_fp_destination;
  logic [0:31] o_condition_reg, o_fp_status_control_reg;
  int num_errors, n_checks;
  logic [2:0] cc [4] = '{3'h0, 3'h1, 3'h1, 3'h0};
  logic [63:0] ca [4] = '{64'h0, 64'h3FF0000000000000, 64'h4000000000000000,
    64'h7FF8000000000000};
  logic [63:0] cb [4] = '{64'h8000000000000000, 64'h4000000000000000,
    64'h3FF0000000000000, 64'h3FF0000000000000};
  logic [3:0] ce [4] = '{4'h2, 4'h8, 4'h4, 4'h1};
  logic [63:0] mb = 64'h0000000080000005;
  fcs_issue_model mdl_u (.i_clk_sys, .i_reset, .i_start(stt), .i_len(ln),
    .o_earlier_fp_pending(i_earlier_fp_pending), .o_exc_record_pending(i_exc_record_pending),
    .o_handler_pending(i_handler_pending));
  fcs_unit dut_u (.i_clk_sys, .i_reset, .i_op_valid, .o_op_ready, .i_op_code, .i_op_dot,
    .i_first_fp_operand, .i_second_fp_operand, .i_target_cr_field, .i_source_status_field,
    .i_target_status_bit, .i_four_bit_constant, .i_field_mask_operand, .o_op_done,
    .o_fp_destination, .o_condition_reg, .o_fp_status_control_reg, .i_earlier_fp_pending,
    .i_exc_record_pending, .i_handler_pending, .o_hold_later_fp, .o_hold_fp_mem,
    .i_exc_set_valid, .i_exc_set_bits, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat,
    .i_wb_sel, .o_wb_dat, .o_wb_ack);
  // Free-running core clock, 100 ns period.
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  // Counts a comparison and reports a difference at once.
  task automatic chk(input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Looks at falling edges so flags are settled; a lost answer ends the run.
  task automatic wait_for(input bit w);
    int n;
    n = 0;
    do begin
      @(negedge i_clk_sys);
      n++;
    end while ((w ? o_wb_ack : o_op_done) !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      wrap_up();
    end
  endtask
  // One classic cycle; request holds until the edge where ack is seen high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} <= {2'h3, w, a, d, 4'hF};
    wait_for(1'b1);
    // Read data is taken at the rising edge where ack is sampled high.
    @(posedge i_clk_sys);
    rq = o_wb_dat;
    {i_wb_cyc, i_wb_stb, i_wb_we} <= 3'h0;
  endtask
  // Issues one op; a nonzero l keeps older work pending for l cycles.
  task automatic op(input logic [2:0] c, input logic d, input logic [63:0] a, b,
      input logic [2:0] f, s, input logic [4:0] t, input logic [3:0] m,
      input logic [7:0] k, input logic [3:0] l);
    @(posedge i_clk_sys);
    {i_op_valid, i_op_code, i_op_dot} <= {1'b1, c, d};
    {i_first_fp_operand, i_second_fp_operand} <= {a, b};
    {i_target_cr_field, i_source_status_field, i_target_status_bit} <= {f, s, t};
    {i_four_bit_constant, i_field_mask_operand, stt, ln} <= {m, k, l != 4'h0, l};
    @(posedge i_clk_sys);
    {i_op_valid, stt} <= 2'h0;
    wait_for(1'b0);
  endtask
  function automatic logic [3:0] fld(input int f);
    return o_condition_reg[4*f +: 4];
  endfunction
  // Main sequence: compares, then status ops with and without older work.
  initial begin
    // A shifted one would be widened to the whole group first and vanish.
    {i_op_valid, i_op_code, i_op_dot, i_first_fp_operand, i_second_fp_operand} = '0;
    i_reset = 1'b1;
    {i_target_cr_field, i_source_status_field, i_target_status_bit, i_four_bit_constant} = '0;
    {i_field_mask_operand, stt, ln, i_exc_set_valid, i_exc_set_bits} = '0;
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} = '0;
    num_errors = 0;
    n_checks = 0;
    repeat (5) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      op(cc[i], 1'b0, ca[i], cb[i], 3'h5, 3'h0, 5'h00, 4'h0, 8'h00, 4'h0);
      chk(ce[i], fld(5));
      chk(ce[i], o_fp_status_control_reg[16:19]);
    end
    wb(1'b1, FCS_ADDR_STATUS, 32'h00000000);
    wb(1'b0, 8'h10, 32'h00000000);
    chk(32'h00000000, rq);
    op(3'h7, 1'b0, 0, 0, 3'h0, 3'h0, 5'h19, 4'h0, 8'h00, 4'h3);
    chk(32'h00000040, o_fp_status_control_reg);
    op(3'h4, 1'b1, 0, 0, 3'h0, 3'h0, 5'h00, 4'h1, 8'h00, 4'h2);
    chk(32'h50000040, o_fp_status_control_reg);
    chk(4'h5, fld(1));
    op(3'h6, 1'b0, 0, 0, 3'h0, 3'h0, 5'h01, 4'h0, 8'h00, 4'h0);
    chk(32'h50000040, o_fp_status_control_reg);
    op(3'h6, 1'b0, 0, 0, 3'h0, 3'h0, 5'h19, 4'h0, 8'h00, 4'h0);
    chk(32'h10000000, o_fp_status_control_reg);
    op(3'h7, 1'b0, 0, 0, 3'h0, 3'h0, 5'h02, 4'h0, 8'h00, 4'h0);
    chk(32'h10000000, o_fp_status_control_reg);
    op(3'h4, 1'b0, 0, 0, 3'h3, 3'h0, 5'h00, 4'hF, 8'h00, 4'h0);
    chk(32'h300F0000, o_fp_status_control_reg);
    chk(4'h5, fld(1));
    op(3'h3, 1'b0, 0, 0, 3'h6, 3'h3, 5'h00, 4'h0, 8'h00, 4'h0);
    chk(4'hF, fld(6));
    chk(32'h10070000, o_fp_status_control_reg);
    op(3'h5, 1'b0, 0, mb, 3'h0, 3'h0, 5'h00, 4'h0, 8'h01, 4'h0);
    chk(32'h10070005, o_fp_status_control_reg);
    op(3'h5, 1'b0, 0, mb, 3'h0, 3'h0, 5'h00, 4'h0, 8'h80, 4'h4);
    chk(32'h80070005, o_fp_status_control_reg);
    op(3'h2, 1'b1, 0, 0, 3'h0, 3'h0, 5'h00, 4'h0, 8'h00, 4'h0);
    chk(32'h80070005, o_fp_destination[32:63]);
    chk(4'h8, fld(1));
    wb(1'b0, FCS_ADDR_DEST_HI, 32'h00000000);
    chk(32'h80070005, rq);
    wb(1'b1, FCS_ADDR_STATUS, 32'h60000000);
    wb(1'b0, FCS_ADDR_STATUS, 32'h00000000);
    chk(32'h00000000, rq);
    wrap_up();
  end
endmodule // fcs_unit_tb
